/* design/ifd_core.sv */
// Instruction sequencer with table read unit.
// Assumes program memory answers word reads combinationally.
// Functional notes
// RULE1 - Instructions are one 16-bit word, four take two words; code also treats 0xEB words as two-word, five in all.
// RULE2 - Single words split into opcode and operand fields.
// RULE3 - Instructions fall into byte, bit, literal and control groups.
// RULE4 - Destination zero writes working register, one writes file.
// RULE5 - Bit instructions carry file, bit number and access fields.
// RULE6 - Literal instructions decode literal and target pointer select.
// RULE7 - Control instructions decode address, return mode, table mode.
// RULE8 - Second word of double-word instructions starts with four ones.
// RULE9 - A lone second word executes as a no-operation.
// RULE10 - One cycle normally; two when branch taken, extra is nop.
// RULE11 - Double-word instructions take two instruction cycles.
// RULE12 - Four oscillator periods per cycle; taken two-word branch three. No two-word branch here is conditional, so all take two.
// RULE13 - Base set of 75 plus 8 extended instructions.
// RULE14 - Table read copies addressed program byte into table latch.
// RULE15 - Table pointer is 21 bits and addresses bytes.
// RULE16 - Pointer bit 0 picks low (0) or high (1) byte.
// RULE17 - Mode 0 none, 1 post-inc, 2 post-dec, 3 pre-inc.
// RULE18 - Table read takes two cycles; latch written at end.
// RULE19 - Pointer updates wrap modulo 21 bits.
`timescale 1ns/1ns
module ifd_core (
    input  wire logic                 sys_clk_in,
    input  wire logic                 nrst_in,
    input  wire logic [15:0]          instr_in,
    input  wire logic                 cond_true_in,
    input  wire logic [15:0]          tbl_data_in,
    output logic [ifd_pkg::TPTR_W-2:0] tbl_word_adr_out,
    output logic                      tbl_rd_out,
    output logic                      fetch_out,
    output logic [1:0]                qphase_out,
    output logic [7:0]                table_latch_out,
    output logic [ifd_pkg::TPTR_W-1:0] table_pointer_out,
    output logic [3:0]                cat_out,
    output logic [5:0]                opcode_out,
    output logic [11:0]               file_adr_out,
    output logic                      wr_working_register_out,
    output logic                      wr_file_out,
    output logic                      access_out,
    output logic [2:0]                bit_num_out,
    output logic [11:0]               literal_out,
    output logic [1:0]                indirect_pointer_reg_sel_out,
    output logic [10:0]               prog_adr_out,
    output logic                      fast_ret_out,
    output logic [1:0]                tbl_mode_out,
    output logic                      extended_out,
    output logic                      exec_nop_out,
    output logic                      instr_done_out
);
    import ifd_pkg::*;
    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    ifd_dec_if dif ();
    ifd_decoder u_dec (
        .d (dif.dec)
    ); // RULE2 RULE3
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ifd_state_t               state_ff, nxt_state;
    logic [1:0]               qph_ff, nxt_qph;
    logic [1:0]               extra_ff, nxt_extra;
    logic                     rd_pend_ff, nxt_rd_pend;
    logic [TPTR_W-1:0]        tptr_ff, nxt_tptr;
    logic [TPTR_W-1:0]        rd_adr_ff, nxt_rd_adr;
    logic [7:0]               latch_ff, nxt_latch;
    logic [15:0]              word_ff, nxt_word;
    logic                     nop_ff, nxt_nop;
    logic                     done_ff, nxt_done;
    logic                     cyc_end;
    logic                     lone_second;

    assign cyc_end     = (qph_ff == QPH_LAST); // RULE12
    assign lone_second = (instr_in[15:12] == SECOND_WORD_TAG); // RULE8
    assign dif.word    = lone_second ? NOP_WORD : instr_in; // RULE9

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_state   = state_ff;
        nxt_qph     = qph_ff + 2'h1;
        nxt_extra   = extra_ff;
        nxt_rd_pend = rd_pend_ff;
        nxt_tptr    = tptr_ff;
        nxt_rd_adr  = rd_adr_ff;
        nxt_latch   = latch_ff;
        nxt_word    = word_ff;
        nxt_nop     = nop_ff;
        nxt_done    = 1'b0;
        if (cyc_end) begin
            case (state_ff)
                IFD_ST_FIRST: begin
                    nxt_word = dif.word;
                    nxt_nop  = lone_second; // RULE9
                    nxt_extra = 2'h0;
                    if (dif.is_two_word) begin
                        nxt_state = IFD_ST_SECOND; // RULE1 RULE11
                        nxt_extra = (dif.is_branch && dif.is_cond
                                     && cond_true_in) ? 2'h1 : 2'h0;
                    end else if (dif.is_tbl_read) begin
                        nxt_state   = IFD_ST_FLUSH; // RULE18
                        nxt_extra   = 2'h1;
                        nxt_rd_pend = 1'b1;
                        case (dif.tbl_mode) // RULE17 RULE19
                            TM_NONE: nxt_rd_adr = tptr_ff;
                            TM_POSTINC: begin
                                nxt_rd_adr = tptr_ff;
                                nxt_tptr   = tptr_ff + TPTR_ONE;
                            end
                            TM_POSTDEC: begin
                                nxt_rd_adr = tptr_ff;
                                nxt_tptr   = tptr_ff - TPTR_ONE;
                            end
                            TM_PREINC: begin
                                nxt_rd_adr = tptr_ff + TPTR_ONE;
                                nxt_tptr   = tptr_ff + TPTR_ONE;
                            end
                            default: nxt_rd_adr = tptr_ff;
                        endcase
                    end else if (dif.is_branch
                                 && (!dif.is_cond || cond_true_in)) begin
                        nxt_state = IFD_ST_FLUSH; // RULE10
                        nxt_extra = 2'h1;
                    end else begin
                        nxt_done = 1'b1; // RULE10
                    end
                end
                IFD_ST_SECOND: begin
                    if (extra_ff != 2'h0) begin
                        nxt_state = IFD_ST_FLUSH; // RULE12
                    end else begin
                        nxt_state = IFD_ST_FIRST;
                        nxt_done  = 1'b1;
                    end
                end
                IFD_ST_FLUSH: begin
                    if (rd_pend_ff) begin // RULE14 RULE16
                        nxt_latch = rd_adr_ff[0] ? tbl_data_in[15:8]
                                                 : tbl_data_in[7:0];
                        nxt_rd_pend = 1'b0;
                    end
                    nxt_state = IFD_ST_FIRST;
                    nxt_done  = 1'b1;
                end
                default: nxt_state = IFD_ST_FIRST;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_ff   <= IFD_ST_FIRST;
            qph_ff     <= 2'h0;
            extra_ff   <= 2'h0;
            rd_pend_ff <= 1'b0;
            tptr_ff    <= TPTR_RST;
            rd_adr_ff  <= TPTR_RST;
            latch_ff   <= LATCH_RST;
            word_ff    <= NOP_WORD;
            nop_ff     <= 1'b0;
            done_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            qph_ff     <= nxt_qph;
            extra_ff   <= nxt_extra;
            rd_pend_ff <= nxt_rd_pend;
            tptr_ff    <= nxt_tptr;
            rd_adr_ff  <= nxt_rd_adr;
            latch_ff   <= nxt_latch;
            word_ff    <= nxt_word;
            nop_ff     <= nxt_nop;
            done_ff    <= nxt_done;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tbl_word_adr_out  = rd_adr_ff[TPTR_W-1:1]; // RULE15
    assign tbl_rd_out        = rd_pend_ff && (state_ff == IFD_ST_FLUSH);
    assign fetch_out         = (state_ff == IFD_ST_FIRST) && cyc_end;
    assign qphase_out        = qph_ff;
    assign table_latch_out   = latch_ff;
    assign table_pointer_out = tptr_ff;
    assign cat_out           = dif.cat; // RULE3
    assign opcode_out        = dif.opcode;
    assign file_adr_out      = dif.file_adr; // RULE5
    assign wr_working_register_out = (dif.cat == IFD_CAT_BYTE)
                                     && !dif.dest_file; // RULE4
    assign wr_file_out       = (dif.cat == IFD_CAT_BYTE)
                               && dif.dest_file; // RULE4
    assign access_out        = dif.access_bit; // RULE5
    assign bit_num_out       = dif.bit_num; // RULE5
    assign literal_out       = dif.literal; // RULE6
    assign indirect_pointer_reg_sel_out = dif.ptr_sel; // RULE6
    assign prog_adr_out      = dif.prog_adr; // RULE7
    assign fast_ret_out      = dif.fast_ret; // RULE7
    assign tbl_mode_out      = dif.tbl_mode; // RULE7
    assign extended_out      = dif.is_extended; // RULE13
    assign exec_nop_out      = nop_ff || (state_ff == IFD_ST_FLUSH);
    assign instr_done_out    = done_ff;
endmodule : ifd_core

/* design/ifd_dec_if.sv */
// Interface carrying decoded fields between core and decoder.
// Assumes both ends in the same clock domain.
`timescale 1ns/1ns
interface ifd_dec_if;
    import ifd_pkg::*;
    logic [15:0] word;
    ifd_cat_t    cat;
    logic [5:0]  opcode;
    logic [11:0] file_adr;
    logic        dest_file;
    logic        access_bit;
    logic [2:0]  bit_num;
    logic [11:0] literal;
    logic [1:0]  ptr_sel;
    logic [10:0] prog_adr;
    logic        fast_ret;
    logic [1:0]  tbl_mode;
    logic        is_two_word;
    logic        is_tbl_read;
    logic        is_branch;
    logic        is_cond;
    logic        is_extended;
    modport dec  (input word, output cat, opcode, file_adr, dest_file,
                  access_bit, bit_num, literal, ptr_sel, prog_adr,
                  fast_ret, tbl_mode, is_two_word, is_tbl_read, is_branch,
                  is_cond, is_extended);
    modport core (output word, input cat, opcode, file_adr, dest_file,
                  access_bit, bit_num, literal, ptr_sel, prog_adr,
                  fast_ret, tbl_mode, is_two_word, is_tbl_read, is_branch,
                  is_cond, is_extended);
endinterface : ifd_dec_if

/* design/ifd_decoder.sv */
// Combinational field splitter for one 16-bit instruction word.
// Assumes the core presents the first word of each instruction.
`timescale 1ns/1ns
module ifd_decoder (
    ifd_dec_if.dec d
);
    import ifd_pkg::*;
    logic [15:0] w;
    assign w = d.word;
    // ------------------------------------------------------------
    // Category and fields
    // ------------------------------------------------------------
    always_comb begin
        d.opcode      = w[15:10];
        d.file_adr    = {4'h0, w[7:0]};
        d.dest_file   = w[9];
        d.access_bit  = w[8];
        d.bit_num     = w[11:9];
        d.literal     = {4'h0, w[7:0]};
        d.ptr_sel     = w[5:4];
        d.prog_adr    = w[10:0];
        d.fast_ret    = w[0];
        d.tbl_mode    = w[1:0];
        d.is_two_word = 1'b0;
        d.is_tbl_read = 1'b0;
        d.is_branch   = 1'b0;
        d.is_cond     = 1'b0;
        d.is_extended = 1'b0;
        d.cat         = IFD_CAT_BYTE;
        if (w[15:12] >= 4'h7 && w[15:12] <= 4'hB) begin
            d.cat       = IFD_CAT_BIT;
            d.is_cond   = (w[15:12] == 4'hA) || (w[15:12] == 4'hB);
        end else if (w[15:8] == 8'h00) begin
            d.cat       = IFD_CAT_CTRL;
            d.is_tbl_read = (w[7:2] == TREAD_TOP[5:0]);
            d.is_branch = (w[7:1] == 7'h09) || (w[7:1] == 7'h08)
                          || (w[7:0] == 8'h14);
        end else if (w[15:12] == 4'hE || w[15:12] == 4'hD) begin
            d.cat       = IFD_CAT_CTRL;
            d.is_branch = 1'b1;
            d.is_cond   = (w[15:11] == 5'h1C);
            d.is_two_word = (w[15:9] == 7'h76) || (w[15:8] == 8'hEF);
            if (w[15:10] == 6'h3A) begin
                d.cat         = IFD_CAT_LIT;
                d.is_branch   = 1'b0;
                d.is_extended = 1'b1;
                d.ptr_sel     = w[7:6];
                d.literal     = {6'h00, w[5:0]};
                d.is_two_word = (w[9:8] == 2'h3);
            end
            if (w[15:6] == 10'h3B8) begin
                d.cat         = IFD_CAT_LIT;
                d.is_branch   = 1'b0;
                d.is_two_word = 1'b1;
                d.ptr_sel     = w[5:4];
                d.literal     = {8'h00, w[3:0]};
            end
        end else if (w[15:12] == 4'hC) begin
            d.is_two_word = 1'b1;
            d.file_adr    = w[11:0];
        end else if (w[15:12] == 4'h0 || w[15:11] == 5'h1F) begin
            d.cat = IFD_CAT_LIT;
        end
    end
endmodule : ifd_decoder

/* design/ifd_pkg.sv */
// Package for the instruction format decoder and table read unit.
// Assumes a single 50 MHz clock and synchronous active-low reset.
package ifd_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int INSTR_W   = 16;
    localparam int TPTR_W    = 21;
    localparam int OSC_PER_CYC = 4;
    localparam logic [1:0] QPH_LAST = 2'h3;
    localparam int BASE_INSTR_CNT = 75;
    localparam int EXT_INSTR_CNT  = 8;
    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [3:0]  SECOND_WORD_TAG = 4'hF;
    localparam logic [13:0] TREAD_TOP       = 14'h0002;
    localparam logic [1:0]  TM_NONE = 2'h0;
    localparam logic [1:0]  TM_POSTINC = 2'h1;
    localparam logic [1:0]  TM_POSTDEC = 2'h2;
    localparam logic [1:0]  TM_PREINC  = 2'h3;
    localparam logic [TPTR_W-1:0] TPTR_ONE = 21'h000001;
    localparam logic [TPTR_W-1:0] TPTR_RST = 21'h000000;
    localparam logic [7:0]  LATCH_RST = 8'h00;
    localparam logic [INSTR_W-1:0] NOP_WORD = 16'h0000;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        IFD_CAT_BYTE = 4'b0001,
        IFD_CAT_BIT  = 4'b0010,
        IFD_CAT_LIT  = 4'b0100,
        IFD_CAT_CTRL = 4'b1000
    } ifd_cat_t;
    typedef enum logic [2:0] {
        IFD_ST_FIRST  = 3'b001,
        IFD_ST_SECOND = 3'b010,
        IFD_ST_FLUSH  = 3'b100
    } ifd_state_t;
endpackage : ifd_pkg

/* testbench/ifd_core_assertions.sv */
// Concurrent checks on the sequencer and table read ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module ifd_core_assertions (
    input  wire logic                          sys_clk_in,
    input  wire logic                          nrst_in,
    input  wire logic                          tbl_rd_out,
    input  wire logic                          fetch_out,
    input  wire logic                          instr_done_out,
    input  wire logic [1:0]                    qphase_out,
    input  wire logic [7:0]                    table_latch_out,
    input  wire logic [15:0]                   tbl_data_in,
    input  wire logic [ifd_pkg::TPTR_W-2:0]    tbl_word_adr_out,
    input  wire logic [ifd_pkg::TPTR_W-1:0]    table_pointer_out
);
    import ifd_pkg::*;
    logic [15:0] data_ff;
    always_ff @(posedge sys_clk_in) begin
        data_ff <= tbl_data_in;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // ------------------------------------------------------------
    // Table read window and cycle timing
    // ------------------------------------------------------------
    sequence s_rd_start;
        !tbl_rd_out ##1 (tbl_rd_out && qphase_out == 2'h0);
    endsequence
    sequence s_rd_body;
        tbl_rd_out [*4] ##1 !tbl_rd_out;
    endsequence
    AST_RD_LEN: assert property (s_rd_start |-> s_rd_body)
        else $error("table read strobe not four clocks");
    AST_QPH_STEP: assert property ($past(nrst_in) |->
        qphase_out == $past(qphase_out) + 2'h1)
        else $error("quarter counter skipped");
    AST_DONE_Q0: assert property (instr_done_out |->
        (qphase_out == 2'h0) ##1 !instr_done_out)
        else $error("done pulse misplaced");
    AST_FETCH_Q4: assert property (fetch_out |->
        (qphase_out == 2'h3) ##1 !fetch_out)
        else $error("fetch outside last quarter");
    AST_LATCH_HOLD: assert property (
        ($past(nrst_in) && !$past(tbl_rd_out)) |-> $stable(table_latch_out))
        else $error("latch changed outside table read");
    AST_LATCH_SRC: assert property ($fell(tbl_rd_out) |->
        (table_latch_out == data_ff[15:8] ||
         table_latch_out == data_ff[7:0]))
        else $error("latch not a byte of the read word");
    AST_ADR_HOLD: assert property ((tbl_rd_out && $past(tbl_rd_out))
        |-> $stable(tbl_word_adr_out))
        else $error("word address moved during read");
    AST_PTR_STEP: assert property (($past(nrst_in) &&
        $changed(table_pointer_out)) |-> (table_pointer_out -
        $past(table_pointer_out)) inside {21'h000001, 21'h1FFFFF})
        else $error("pointer moved by more than one");
    AST_PTR_WHEN: assert property (($past(nrst_in) &&
        $changed(table_pointer_out)) |->
        (tbl_rd_out || $past(tbl_rd_out)))
        else $error("pointer moved outside table read");
endmodule // ifd_core_assertions

/* testbench/ifd_prog_mem.sv */
// Program memory model answering table word reads.
// Assumes word address and read strobe from the core.
`timescale 1ns/1ns
module ifd_prog_mem (
    input  wire logic [19:0] word_adr_in,
    input  wire logic        rd_in,
    output logic      [15:0] data_out
);
    logic [15:0] word;
    assign word = {word_adr_in[7:0] ^ word_adr_in[19:12], ~word_adr_in[7:0]};
    // Idle bus shows the inverse, never the last word
    assign data_out = rd_in ? word : ~word;
endmodule // ifd_prog_mem

/* testbench/testbench.sv */
// Self-checking bench for the sequencer and table read unit.
// Assumes the program memory model on the table read port.
`timescale 1ns/1ns
module testbench;
    import ifd_pkg::*;
    logic        sys_clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        cond_true_in = 1'b0;
    logic [15:0] instr_in = NOP_WORD;
    logic [15:0] tbl_data_in;
    logic [15:0] w;
    logic [19:0] tbl_word_adr_out;
    logic [20:0] table_pointer_out;
    logic [20:0] ptr_exp = 21'h000000;
    logic [11:0] file_adr_out, literal_out;
    logic [7:0]  table_latch_out;
    logic [5:0]  opcode_out;
    logic [3:0]  cat_out;
    logic [2:0]  bit_num_out;
    logic [1:0]  qphase_out, ptr_sel_out, tbl_mode_out;
    logic        tbl_rd_out, fetch_out, wr_wr_out, wr_file_out, access_out;
    logic        fast_ret_out, exec_nop_out, instr_done_out, nop_seen;
    logic        extended_out;
    logic [10:0] prog_adr_out;
    int          miscompares = 0;
    int          tests_run = 0;
    int          n_clk;
    always #10 sys_clk_in = ~sys_clk_in;
    ifd_core uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .instr_in(instr_in), .cond_true_in(cond_true_in),
        .tbl_data_in(tbl_data_in), .tbl_word_adr_out(tbl_word_adr_out),
        .tbl_rd_out(tbl_rd_out), .fetch_out(fetch_out),
        .qphase_out(qphase_out), .table_latch_out(table_latch_out),
        .table_pointer_out(table_pointer_out), .cat_out(cat_out),
        .opcode_out(opcode_out), .file_adr_out(file_adr_out),
        .wr_working_register_out(wr_wr_out), .wr_file_out(wr_file_out),
        .access_out(access_out), .bit_num_out(bit_num_out),
        .literal_out(literal_out), .indirect_pointer_reg_sel_out(ptr_sel_out),
        .prog_adr_out(prog_adr_out), .fast_ret_out(fast_ret_out),
        .tbl_mode_out(tbl_mode_out), .extended_out(extended_out),
        .exec_nop_out(exec_nop_out), .instr_done_out(instr_done_out));
    ifd_prog_mem u_mem (.word_adr_in(tbl_word_adr_out), .rd_in(tbl_rd_out),
        .data_out(tbl_data_in));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic [20:0] a);
        logic [15:0] wd;
        wd = {a[8:1] ^ a[20:13], ~a[8:1]};
        return a[0] ? wd[15:8] : wd[7:0];
    endfunction
    // Present a word at a falling edge, count clocks to done
    task automatic run(input logic [15:0] wd, input logic c);
        n_clk = 0;
        nop_seen = 1'b0;
        instr_in = wd;
        cond_true_in = c;
        do begin
            @(negedge sys_clk_in);
            n_clk++;
            nop_seen = nop_seen | exec_nop_out;
        end while (instr_done_out !== 1'b1 && n_clk < 200);
        if (n_clk >= 200) begin
            miscompares++;
            finish_test();
        end
    endtask
    task automatic tbl(input logic [1:0] m);
        logic [20:0] a;
        if (m == TM_PREINC) ptr_exp = ptr_exp + TPTR_ONE;
        a = ptr_exp;
        if (m == TM_POSTINC) ptr_exp = ptr_exp + TPTR_ONE;
        if (m == TM_POSTDEC) ptr_exp = ptr_exp - TPTR_ONE;
        run({TREAD_TOP, m}, 1'b0);
        check(n_clk, 8);
        check(tbl_mode_out, m);
        check(table_latch_out, exp_byte(a));
        check(table_pointer_out, ptr_exp);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(4461));
        repeat (3) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        run(NOP_WORD, 1'b0);
        check(table_latch_out, LATCH_RST);
        run(NOP_WORD, 1'b0);
        check(n_clk, 4);
        repeat (6) begin
            w = {6'h09, 10'($urandom)};
            run(w, 1'b0);
            check(n_clk, 4);
            check(nop_seen, 0);
            check(cat_out, IFD_CAT_BYTE);
            check(opcode_out, w[15:10]);
            check(wr_file_out, w[9]);
            check(wr_wr_out, !w[9]);
            check(file_adr_out[7:0], w[7:0]);
            check(extended_out, 0);
        end
        w = {4'h8, 12'($urandom)};
        run(w, 1'b0);
        check(cat_out, IFD_CAT_BIT);
        check(bit_num_out, w[11:9]);
        check(access_out, w[8]);
        check(file_adr_out[7:0], w[7:0]);
        w = {8'h0E, 8'($urandom)};
        run(w, 1'b0);
        check(cat_out, IFD_CAT_LIT);
        check(literal_out[7:0], w[7:0]);
        w = {10'h3B8, 6'($urandom)};
        run(w, 1'b0);
        check(n_clk, 8);
        check(ptr_sel_out, w[5:4]);
        run(16'h0013, 1'b0);
        check(n_clk, 8);
        check(fast_ret_out, 1);
        check(cat_out, IFD_CAT_CTRL);
        run({SECOND_WORD_TAG, 12'($urandom)}, 1'b0);
        check(n_clk, 4);
        check(nop_seen, 1);
        w = {8'hE0, 8'($urandom)};
        run(w, 1'b1);
        check(n_clk, 8);
        check(nop_seen, 1);
        run(w, 1'b0);
        check(n_clk, 4);
        run({8'hEF, 8'($urandom)}, 1'b0);
        check(n_clk, 8);
        w = {8'hE8, 1'b0, 7'($urandom)};
        run(w, 1'b0);
        check(n_clk, 4);
        check(extended_out, 1);
        check(ptr_sel_out, w[7:6]);
        w = {5'h1A, 11'($urandom)};
        run(w, 1'b0);
        check(n_clk, 8);
        check(prog_adr_out, w[10:0]);
        w = {4'hC, 12'($urandom)};
        run(w, 1'b0);
        check(n_clk, 8);
        check(file_adr_out, w[11:0]);
        tbl(TM_POSTDEC);
        tbl(TM_PREINC);
        tbl(TM_NONE);
        repeat (12) tbl(2'($urandom));
        // Mid-run reset clears pointer and latch
        nrst_in = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        check(table_pointer_out, TPTR_RST);
        check(table_latch_out, LATCH_RST);
        ptr_exp = TPTR_RST;
        tbl(TM_POSTINC);
        finish_test();
    end
endmodule // testbench

bind ifd_core ifd_core_assertions u_chk (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .tbl_rd_out(tbl_rd_out), .fetch_out(fetch_out),
    .instr_done_out(instr_done_out), .qphase_out(qphase_out),
    .table_latch_out(table_latch_out), .tbl_data_in(tbl_data_in),
    .tbl_word_adr_out(tbl_word_adr_out),
    .table_pointer_out(table_pointer_out));
